/* rtl/tap_pkg.sv */
// tap_pkg: shared constants and types for the scan-port controller
// assumes a single core clock that oversamples the test clock pin
`default_nettype none
package tap_pkg;
  localparam int unsigned IR_W = 8;
  localparam logic [7:0] IR_CAPTURE = 8'h81;        // fixed capture pattern 10000001
  localparam logic [7:0] IR_BYPASS  = 8'hFF;        // all-ones selects bypass
  localparam logic [7:0] IR_RESET   = 8'hFF;        // reset selects bypass
  localparam int unsigned DR_W = 8;                 // width of the generic user data register
  localparam logic [7:0] DR_RESET   = 8'h00;
  localparam int unsigned SYNC_W = 3;
  localparam int unsigned CORE_PERIOD_NS = 100;

  typedef enum logic [3:0] {
    ST_RESET  = 4'h0, ST_IDLE   = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SH_DR  = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR  = 4'h6, ST_EX2_DR = 4'h7,
    ST_UP_DR  = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR  = 4'hB,
    ST_EX1_IR = 4'hC, ST_PA_IR  = 4'hD, ST_EX2_IR = 4'hE, ST_UP_IR  = 4'hF
  } tap_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } link_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } link_out_t;
endpackage : tap_pkg
`default_nettype wire

/* rtl/tap_ctrl.sv */
// tap_ctrl: four-wire scan-port controller with instruction and bypass registers
// assumes test pins arrive asynchronously; core_clk is much faster than the test clock
// Notes on behaviour
// - apart from the synchronisers, edge detector and bypass_sel, every register and state changes only at a detected test clock edge.
// - the mode and data inputs are sampled at the rising test clock edge.
// - the serial output and its enable change only at the falling test clock edge.
// - from the reset state a low mode input at a rising edge moves to idle.
// - the controller walks through idle and both select states to an instruction scan.
// - leaving instruction capture loads the pattern 10000001 into the shift stage.
// - entering a shift state enables the serial output at the falling edge.
// - in instruction shift one bit enters per rising edge while the old bits leave.
// - the last instruction bit shifts as the state moves to exit1.
// - at the falling edge in either exit1 state the serial output is released.
// - the instruction is updated at the falling edge in instruction update; all ones is bypass.
// - leaving data capture with bypass selected clears the bypass bit.
// - in bypass the input appears on the output one bit later.
// - the selected data register takes the shifted data at the falling edge in data update.
// - after data update the walk through both select states returns to reset.
`default_nettype none
module tap_ctrl
  import tap_pkg::*;
#(
  parameter int unsigned DR_WIDTH = DR_W
) (
  // core clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  // test link pins
  input  wire link_in_t            link_in,
  output var  link_out_t           link_out,
  // decoded state for the surrounding logic
  output var  logic [IR_W-1:0]     instr,
  output var  logic [DR_WIDTH-1:0] user_dr,
  output var  logic                bypass_sel
);

  // three-stage synchronisers for the pins
  logic [SYNC_W-1:0] tck_s_q, tms_s_q, tdi_s_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_s_q <= '0;
      tms_s_q <= '0;
      tdi_s_q <= '0;
    end else begin
      tck_s_q <= {tck_s_q[1:0], link_in.tck};
      tms_s_q <= {tms_s_q[1:0], link_in.tms};
      tdi_s_q <= {tdi_s_q[1:0], link_in.tdi};
    end
  end

  // edge detection waits until the synchroniser holds the pin's own level,
  // so a test clock that idles high gives no false rising edge after reset
  localparam int unsigned ARM_CNT = SYNC_W + 1;
  logic [2:0] arm_cnt_q;
  logic       armed;
  assign armed = (arm_cnt_q == 3'(ARM_CNT));
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) arm_cnt_q <= '0;
    else if (!armed) arm_cnt_q <= arm_cnt_q + 3'h1;
  end

  // filtered test clock level: changes once stages two and three agree
  logic tck_lvl_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) tck_lvl_q <= 1'b0;
    else if (!armed || tck_s_q[1] == tck_s_q[2]) tck_lvl_q <= tck_s_q[2];
  end

  logic rise, fall;
  assign rise = armed && (tck_s_q[1] == tck_s_q[2]) && tck_s_q[2] && !tck_lvl_q;
  assign fall = armed && (tck_s_q[1] == tck_s_q[2]) && !tck_s_q[2] && tck_lvl_q;

  // tms and tdi are taken from the same stage as the clock edge
  logic tms_i, tdi_i;
  assign tms_i = tms_s_q[2];
  assign tdi_i = tdi_s_q[2];

  // next-state function of the sixteen-state controller
  function automatic tap_state_t next_state(tap_state_t s, logic m);
    unique case (s)
      ST_RESET:  next_state = m ? ST_RESET  : ST_IDLE;
      ST_IDLE:   next_state = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_state = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = m ? ST_UP_DR  : ST_PA_DR;
      ST_PA_DR:  next_state = m ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: next_state = m ? ST_UP_DR  : ST_SH_DR;
      ST_UP_DR:  next_state = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = m ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: next_state = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_state = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = m ? ST_UP_IR  : ST_PA_IR;
      ST_PA_IR:  next_state = m ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: next_state = m ? ST_UP_IR  : ST_SH_IR;
      ST_UP_IR:  next_state = m ? ST_SEL_DR : ST_IDLE;
    endcase
  endfunction

  // controller state advances on rising test clock edges
  tap_state_t state_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) state_q <= ST_RESET;
    else if (rise) state_q <= next_state(state_q, tms_i);
  end

  // instruction shift stage
  logic [IR_W-1:0] ir_sh_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) ir_sh_q <= '0;
    else if (rise) begin
      if (state_q == ST_CAP_IR) ir_sh_q <= IR_CAPTURE;
      else if (state_q == ST_SH_IR) ir_sh_q <= {tdi_i, ir_sh_q[IR_W-1:1]};
    end
  end

  // instruction register updates on the falling edge in update-ir
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) instr <= IR_RESET;
    else if (fall) begin
      if (state_q == ST_RESET) instr <= IR_RESET;
      else if (state_q == ST_UP_IR) instr <= ir_sh_q;
    end
  end

  // bypass selection mirrors the current instruction
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) bypass_sel <= 1'b1;
    else bypass_sel <= (instr == IR_BYPASS);
  end

  // bypass bit and generic data shift stage
  logic                bp_q;
  logic [DR_WIDTH-1:0] dr_sh_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bp_q    <= 1'b0;
      dr_sh_q <= '0;
    end else if (rise) begin
      if (state_q == ST_CAP_DR) begin
        bp_q    <= 1'b0;
        dr_sh_q <= user_dr;
      end else if (state_q == ST_SH_DR) begin
        if (bypass_sel) bp_q <= tdi_i;
        else dr_sh_q <= {tdi_i, dr_sh_q[DR_WIDTH-1:1]};
      end
    end
  end

  // selected data register updates on the falling edge in update-dr
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) user_dr <= DR_RESET;
    else if (fall && state_q == ST_UP_DR && !bypass_sel) user_dr <= dr_sh_q;
  end

  // serial output and enable change only at falling edges
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) link_out <= '0;
    else if (fall) begin
      unique case (state_q)
        ST_SH_IR: link_out <= '{tdo: ir_sh_q[0], tdo_oe: 1'b1};
        ST_SH_DR: link_out <= '{tdo: bypass_sel ? bp_q : dr_sh_q[0], tdo_oe: 1'b1};
        default:  link_out <= '{tdo: 1'b0, tdo_oe: 1'b0};
      endcase
    end
  end

  // the enable only moves at a falling edge
  AST_OE_ON_FALL: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(link_out.tdo_oe) |-> $past(fall)) else $error("tdo enable moved off edge");
  // tdo never changes without a falling edge
  AST_TDO_ON_FALL: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(link_out.tdo) |-> $past(fall)) else $error("tdo moved off edge");
  // state only moves at rising edges
  AST_STATE_ON_RISE: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(state_q) |-> $past(rise)) else $error("state moved off edge");
  // reset state with low tms goes to idle
  AST_RESET_TO_IDLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    rise && state_q == ST_RESET && !tms_i |=> state_q == ST_IDLE)
    else $error("no idle from reset");
  // capture-ir loads the fixed pattern
  sequence cap_ir_exit_s;
    rise && state_q == ST_CAP_IR;
  endsequence
  AST_IR_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_b)
    cap_ir_exit_s |=> ir_sh_q == IR_CAPTURE) else $error("ir capture wrong");
  // shift-ir moves tdi into the top bit
  AST_IR_SHIFT: assert property (@(posedge core_clk) disable iff (!rst_b)
    rise && state_q == ST_SH_IR |=> ir_sh_q[IR_W-1] == $past(tdi_i))
    else $error("ir shift wrong");
  // exit1 falling edge releases tdo
  AST_EXIT_RELEASE: assert property (@(posedge core_clk) disable iff (!rst_b)
    fall && (state_q == ST_EX1_IR || state_q == ST_EX1_DR) |=> !link_out.tdo_oe)
    else $error("tdo not released");
  // update-ir copies the shift stage
  AST_IR_UPDATE: assert property (@(posedge core_clk) disable iff (!rst_b)
    fall && state_q == ST_UP_IR |=> instr == $past(ir_sh_q)) else $error("ir update wrong");
  // bypass capture clears the bit
  AST_BP_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_b)
    rise && state_q == ST_CAP_DR |=> !bp_q) else $error("bypass capture wrong");
  // shift-dr in bypass moves tdi into the bypass bit
  AST_BP_SHIFT: assert property (@(posedge core_clk) disable iff (!rst_b)
    rise && state_q == ST_SH_DR && bypass_sel |=> bp_q == $past(tdi_i))
    else $error("bypass shift wrong");
  // update-dr copies the data shift stage when not in bypass
  AST_DR_UPDATE: assert property (@(posedge core_clk) disable iff (!rst_b)
    fall && state_q == ST_UP_DR && !bypass_sel |=> user_dr == $past(dr_sh_q))
    else $error("dr update wrong");
  // a falling edge in a shift state drives tdo
  AST_OE_IN_SHIFT: assert property (@(posedge core_clk) disable iff (!rst_b)
    fall && (state_q == ST_SH_IR || state_q == ST_SH_DR) |=> link_out.tdo_oe)
    else $error("tdo not enabled in shift");
  // a falling edge in reset reloads the bypass instruction
  AST_INSTR_RESET: assert property (@(posedge core_clk) disable iff (!rst_b)
    fall && state_q == ST_RESET |=> instr == IR_RESET)
    else $error("instruction not reloaded in reset");
  // no edge is seen before the synchroniser is filled
  AST_NO_EDGE_UNARMED: assert property (@(posedge core_clk) disable iff (!rst_b)
    !armed |-> !rise && !fall)
    else $error("edge seen before arming");

endmodule // tap_ctrl
`default_nettype wire

/* verification/jtag_host.sv */
// jtag_host: behavioural far-end test controller for the scan port
// assumes tick is called at a core falling edge, once per test clock
`default_nettype none
module jtag_host
  import tap_pkg::*;
(
  // scan pins toward the device
  output var  link_in_t  pins,
  // serial answer from the device
  input  wire link_out_t resp
);
  timeunit 1ns;
  timeprecision 1ns;

  // test clock stands high between frames; mode and data idle high
  initial pins = 3'h7;

  // one test clock: pins change at the fall, the rising edge follows
  task automatic tick(input logic tms_v, input logic tdi_v,
                      output logic tdo_v, output logic oe_v);
    pins.tck = 1'b0;
    pins.tms = tms_v;
    pins.tdi = tdi_v;
    #400;
    pins.tck = 1'b1;
    #300;
    tdo_v = resp.tdo;     // settled late in the high phase
    oe_v  = resp.tdo_oe;
    #100;
  endtask
endmodule // jtag_host
`default_nettype wire

/* verification/tb_jtag_tap_scan_sequencing.sv */
// tb_jtag_tap_scan_sequencing: self-checking bench for the scan-port controller
// assumes jtag_host stands in for the external test controller
`default_nettype none
module tb_jtag_tap_scan_sequencing;
  import tap_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic            core_clk;
  logic            rst_b;
  link_in_t        pins;
  link_out_t       resp;
  logic [IR_W-1:0] instr;
  logic [DR_W-1:0] user_dr;
  logic            bypass_sel;
  logic            tdo_s;
  logic            oe_s;
  logic [7:0]      got;
  int              mismatches;
  int              compares;
  // walk rows, one per test clock: {tms, tdi, expected enable, expected data}
  logic [3:0] rows [25] = '{4'h4, 4'hC, 4'hC, 4'h4, 4'h4, 4'h7, 4'h6, 4'h6, 4'h6,
    4'h6, 4'h6, 4'h6, 4'hF, 4'hC, 4'hC, 4'h4, 4'h4, 4'h6, 4'h3, 4'hE, 4'hC, 4'hC,
    4'hC, 4'hC, 4'hC};

  tap_ctrl #(.DR_WIDTH(DR_W)) u_dut (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .link_in    (pins),
    .link_out   (resp),
    .instr      (instr),
    .user_dr    (user_dr),
    .bypass_sel (bypass_sel)
  );
  jtag_host u_host (.pins(pins), .resp(resp));

  // core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // from idle or reset: into a shift state, move 8 bits, update, back to idle
  task automatic scan(input logic ir, input logic [7:0] val, output logic [7:0] o);
    u_host.tick(1'b0, 1'b1, tdo_s, oe_s);
    u_host.tick(1'b1, 1'b1, tdo_s, oe_s);
    if (ir) begin
      u_host.tick(1'b1, 1'b1, tdo_s, oe_s);
    end
    u_host.tick(1'b0, 1'b1, tdo_s, oe_s);
    u_host.tick(1'b0, 1'b1, tdo_s, oe_s);
    for (int i = 0; i < 8; i++) begin
      u_host.tick(i == 7, val[i], tdo_s, oe_s);
      o[i] = tdo_s;
    end
    u_host.tick(1'b1, 1'b1, tdo_s, oe_s);
    u_host.tick(1'b0, 1'b1, tdo_s, oe_s);
  endtask

  // verdict and end of run
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 25; i++) begin
      u_host.tick(rows[i][3], rows[i][2], tdo_s, oe_s);
      chk(8'(oe_s), 8'(rows[i][1]));
      if (rows[i][1]) begin
        chk(8'(tdo_s), 8'(rows[i][0]));
      end
    end
    chk(instr, IR_BYPASS);
    $display("walk test done");
    scan(1'b1, 8'h00, got);
    chk(got, IR_CAPTURE);
    chk(instr, 8'h00);
    chk({7'h00, bypass_sel}, 8'h00);
    scan(1'b0, 8'hA5, got);
    chk(got, DR_RESET);
    chk(user_dr, 8'hA5);
    for (int i = 0; i < 6; i++) begin
      u_host.tick(1'b1, 1'b1, tdo_s, oe_s);
    end
    chk(instr, IR_RESET);
    $display("user register test done");
    for (int i = 0; i < 5; i++) begin
      u_host.tick(i == 1, 1'b0, tdo_s, oe_s);
    end
    chk(8'(oe_s), 8'h01);
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(8'(resp.tdo_oe), 8'h00);
    chk(instr, IR_RESET);
    chk(user_dr, DR_RESET);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    u_host.tick(1'b0, 1'b0, tdo_s, oe_s);
    chk(8'(oe_s), 8'h00);
    $display("mid-shift reset test done");
    complete_run();
  end
endmodule // tb_jtag_tap_scan_sequencing
`default_nettype wire
